/* hw/sfp_flash_seq.sv */
// Purpose: page program and flag-clear command handling of a serial flash
// Assumes: link frames are framed by sel_n_in, data sampled on sclk rising
// Notes: sclk_in only toggles inside frames; frame results are read by
//        mclk only after select has risen and passed its synchroniser
`default_nettype none

module sfp_flash_seq #(
	parameter int PAGE_BYTES = sfp_pkg::PAGE_BYTES_DEF,
	parameter int TPP_MAX_NS = sfp_pkg::TPP_MAX_NS_DEF
) (
	// system clock and reset
	input wire logic mclk_in,
	input wire logic reset_in,
	// serial link
	input wire logic sclk_in,
	input wire logic sel_n_in,
	input wire logic [3:0] io_lane_in,
	// configuration and neighbouring command hooks
	input wire sfp_pkg::sfp_mode_e lane_mode_in,
	input wire logic wren_cmd_in,
	input wire logic suspend_req_in,
	input wire logic resume_req_in,
	input wire logic [sfp_pkg::NUM_SECT-1:0] sect_prot_in,
	// storage array
	input wire logic [7:0] arr_rdata_in,
	input wire logic arr_ack_in,
	output sfp_pkg::sfp_arr_req_s arr_req_out,
	// status registers
	output logic [7:0] status_out,
	output logic [7:0] flag_status_out
);
	import sfp_pkg::*;

	localparam int OFF_W = $clog2(PAGE_BYTES); // byte-in-page bits
	localparam logic [OFF_W-1:0] OFF_LAST = OFF_W'(PAGE_BYTES - 1);
	// longest program time rounds down, never below one cycle
	localparam int TPP_RAW = (TPP_MAX_NS / NS_PER_US) * MCLK_MHZ;
	localparam logic [31:0] TPP_CYC = 32'((TPP_RAW < 1) ? 1 : TPP_RAW);

	// ---------------- link clock domain ----------------

	logic io_lane_zero; // the single-lane input
	sfp_mode_e mode_s1_q, mode_s2_q; // mode in link domain, two edges late
	logic busy_s1_q, busy_s2_q; // busy into link domain
	logic fresh_q; // no link edge yet in this frame
	logic frame_rst; // select high or global reset
	logic tog_q; // flips at each frame's first edge
	sfp_phase_e phase_q, cur_phase;
	logic [3:0] bits_q, cur_bits, nbits;
	logic [3:0] lw; // lanes used this edge
	logic [7:0] sh_q, nsh; // byte being assembled
	logic [7:0] opcode_q, sr_q; // sr_q is the status register
	logic [ADDR_W-1:0] addr_q;
	logic [1:0] acnt_q, cur_acnt;
	logic [15:0] dcnt_q, cur_dcnt;
	logic blk_q, cur_blk; // frame began while busy
	logic byte_done;
	logic buf_wr, buf_clr;
	logic [OFF_W-1:0] buf_woff;

	assign io_lane_zero = io_lane_in[0];
	assign frame_rst = reset_in | sel_n_in;

	// lane count for the current phase; extended mode widens per opcode
	function automatic logic [3:0] lane_width(input sfp_mode_e m,
			input sfp_phase_e p, input logic [7:0] op);
		logic [3:0] w;
		w = (m == MODE_QUAD) ? W_QUAD : (m == MODE_DUAL) ? W_DUAL : W_SINGLE;
		if (m == MODE_EXT && p != PH_CMD) begin
			if (op == OP_PP_QUAD_EXT || (op == OP_PP_QUAD && p == PH_DATA)) begin
				w = W_QUAD;
			end else if (op == OP_PP_DUAL_EXT ||
					(op == OP_PP_DUAL && p == PH_DATA)) begin
				w = W_DUAL;
			end
		end
		return w;
	endfunction

	// configuration and busy are levels; two flops before use
	always_ff @(posedge sclk_in or posedge reset_in) begin
		if (reset_in) begin
			mode_s1_q <= MODE_EXT;
			mode_s2_q <= MODE_EXT;
			busy_s1_q <= 1'b0;
			busy_s2_q <= 1'b0;
		end else begin
			mode_s1_q <= lane_mode_in;
			mode_s2_q <= mode_s1_q;
			busy_s1_q <= sr_q[SR_WIP];
			busy_s2_q <= busy_s1_q;
		end
	end

	// armed by select high; the first edge of a frame disarms it
	always_ff @(posedge sclk_in or posedge frame_rst) begin
		if (frame_rst) begin
			fresh_q <= 1'b1;
		end else begin
			fresh_q <= 1'b0;
		end
	end

	// first edge of a frame starts from clean counters
	always_comb begin
		cur_phase = fresh_q ? PH_CMD : phase_q;
		cur_bits = fresh_q ? 4'h0 : bits_q;
		cur_acnt = fresh_q ? 2'h0 : acnt_q;
		cur_dcnt = fresh_q ? 16'h0000 : dcnt_q;
		cur_blk = fresh_q ? busy_s2_q : blk_q;
		lw = lane_width(mode_s2_q, cur_phase, opcode_q);
		// all active lanes enter together, msb first
		unique case (lw)
			W_QUAD: nsh = {sh_q[3:0], io_lane_in};
			W_DUAL: nsh = {sh_q[5:0], io_lane_in[1:0]};
			default: nsh = {sh_q[6:0], io_lane_zero};
		endcase
		nbits = cur_bits + lw;
		byte_done = (nbits == BYTE_BITS);
	end

	// data bytes land at start offset plus count, modulo the page
	assign buf_woff = addr_q[OFF_W-1:0] + cur_dcnt[OFF_W-1:0];
	assign buf_wr = byte_done && cur_phase == PH_DATA && !cur_blk;
	assign buf_clr = fresh_q && !busy_s2_q;

	// frame marker, read by mclk once the frame is over
	always_ff @(posedge sclk_in or posedge reset_in) begin
		if (reset_in) begin
			tog_q <= 1'b0;
		end else if (fresh_q) begin
			tog_q <= ~tog_q;
		end
	end

	// frame decoder; every field is sampled on the rising link edge
	always_ff @(posedge sclk_in or posedge reset_in) begin
		if (reset_in) begin
			phase_q <= PH_CMD;
			bits_q <= 4'h0;
			sh_q <= 8'h00;
			opcode_q <= 8'h00;
			addr_q <= '0;
			acnt_q <= 2'h0;
			dcnt_q <= 16'h0000;
			blk_q <= 1'b0;
		end else begin
			sh_q <= nsh;
			bits_q <= byte_done ? 4'h0 : nbits;
			phase_q <= cur_phase;
			acnt_q <= cur_acnt;
			dcnt_q <= cur_dcnt;
			blk_q <= cur_blk;
			if (byte_done) begin
				unique case (cur_phase)
					PH_CMD: begin
						opcode_q <= nsh;
						phase_q <= sfp_is_prog(nsh) ? PH_ADDR : PH_OTHER;
					end
					PH_ADDR: begin
						addr_q <= {addr_q[ADDR_W-9:0], nsh};
						acnt_q <= cur_acnt + 2'h1;
						if (cur_acnt == 2'(ADDR_BYTES - 1)) begin
							phase_q <= PH_DATA;
						end
					end
					PH_DATA: begin
						// count saturates; only the byte position matters
						if (cur_dcnt != DCNT_MAX) begin
							dcnt_q <= cur_dcnt + 16'h0001;
						end
					end
					PH_OTHER: begin
						// bytes of other commands are ignored
					end
				endcase
			end
		end
	end

	// ---------------- system clock domain ----------------

	sfp_frame_s frm; // frozen result of the finished frame
	logic sel_s1_q, sel_s2_q, sel_s3_q; // select synchroniser
	logic seen_q; // last frame marker consumed
	logic end_evt, new_frame;
	logic prog_ok, prot, start_prog, prot_hit, clr_req;
	logic running, timeout, end_op;
	sfp_state_e state_q;
	logic [OFF_W-1:0] off_q; // byte being programmed
	logic [ADDR_W-OFF_W-1:0] page_q; // page being programmed
	logic [31:0] timer_q;
	logic susp_pend_q;
	logic [7:0] sr_d, fsr_q, fsr_d;
	logic [7:0] sr_set, sr_clr, fsr_set, fsr_clr;
	sfp_arr_req_s arr_q;
	logic [7:0] buf_rdata;
	logic buf_rvalid;

	// link regs are static here: no link edges once select is high
	assign frm = '{opcode: opcode_q, phase: phase_q, bits: bits_q,
		addr: addr_q, dcnt: dcnt_q, blocked: blk_q};

	// select is a pin; two flops, then a third for the edge
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			sel_s1_q <= 1'b1;
			sel_s2_q <= 1'b1;
			sel_s3_q <= 1'b1;
		end else begin
			sel_s1_q <= sel_n_in;
			sel_s2_q <= sel_s1_q;
			sel_s3_q <= sel_s2_q;
		end
	end

	assign end_evt = sel_s2_q && !sel_s3_q;
	// a frame with no link edges leaves the marker alone
	assign new_frame = end_evt && (tog_q != seen_q);

	// remember which frame was already judged
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			seen_q <= 1'b0;
		end else if (end_evt) begin
			seen_q <= tog_q;
		end
	end

	// judge the finished frame
	always_comb begin
		// whole bytes only: select must rise on a byte boundary
		prog_ok = new_frame && sfp_is_prog(frm.opcode) &&
			frm.phase == PH_DATA && frm.bits == 4'h0 &&
			frm.dcnt != 16'h0000 && !frm.blocked &&
			sr_q[SR_WEL] && state_q == ST_IDLE;
		prot = sect_prot_in[frm.addr[ADDR_W-1:SECT_LSB]];
		start_prog = prog_ok && !prot;
		prot_hit = prog_ok && prot;
		// opcode byte is enough; later bits or none do not matter
		clr_req = new_frame && frm.opcode == OP_CLR_FLAG &&
			frm.phase == PH_OTHER;
		running = (state_q == ST_SCAN) || (state_q == ST_RMW) ||
			(state_q == ST_WACK);
		timeout = running && (timer_q >= TPP_CYC);
		end_op = (state_q == ST_FINISH) || timeout;
	end

	// staging buffer between the link and the sequencer
	sfp_page_buf #(
		.PAGE_BYTES(PAGE_BYTES)
	) u_buf (
		.wclk_in(sclk_in),
		.reset_in(reset_in),
		.clr_in(buf_clr),
		.wr_en_in(buf_wr),
		.wr_off_in(buf_woff),
		.wr_data_in(nsh),
		.rd_off_in(off_q),
		.rd_data_out(buf_rdata),
		.rd_valid_out(buf_rvalid)
	);

	// self-timed program walk over the staged page
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			state_q <= ST_IDLE;
			off_q <= '0;
			page_q <= '0;
			arr_q <= '0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (start_prog) begin
						off_q <= '0;
						page_q <= frm.addr[ADDR_W-1:OFF_W];
						state_q <= ST_SCAN;
					end
				end
				ST_SCAN: begin
					if (timeout) begin
						state_q <= ST_IDLE;
					end else if (susp_pend_q) begin
						state_q <= ST_SUSP;
					end else if (buf_rvalid) begin
						arr_q.addr <= {page_q, off_q};
						state_q <= ST_RMW;
					end else if (off_q == OFF_LAST) begin
						state_q <= ST_FINISH;
					end else begin
						off_q <= off_q + 1'b1;
					end
				end
				ST_RMW: begin
					if (timeout) begin
						state_q <= ST_IDLE;
					end else begin
						// old data and new: a zero can never rise
						arr_q.wdata <= arr_rdata_in & buf_rdata;
						arr_q.we <= 1'b1;
						state_q <= ST_WACK;
					end
				end
				ST_WACK: begin
					if (timeout) begin
						arr_q.we <= 1'b0;
						state_q <= ST_IDLE;
					end else if (arr_ack_in) begin
						arr_q.we <= 1'b0;
						if (off_q == OFF_LAST) begin
							state_q <= ST_FINISH;
						end else begin
							off_q <= off_q + 1'b1;
							state_q <= ST_SCAN;
						end
					end
				end
				ST_SUSP: begin
					// array is quiet here; the timer is frozen too
					if (resume_req_in) begin
						state_q <= ST_SCAN;
					end
				end
				ST_FINISH: begin
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// elapsed program time; suspended time does not count
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			timer_q <= 32'h0000_0000;
		end else if (start_prog) begin
			timer_q <= 32'h0000_0000;
		end else if (running) begin
			timer_q <= timer_q + 32'h0000_0001;
		end
	end

	// suspend may arrive mid byte; it is honoured between bytes
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			susp_pend_q <= 1'b0;
		end else if (suspend_req_in && running) begin
			susp_pend_q <= 1'b1;
		end else if (state_q == ST_SUSP || state_q == ST_IDLE) begin
			susp_pend_q <= 1'b0;
		end
	end

	// set and clear terms of both status registers
	always_comb begin
		sr_set = 8'h00;
		sr_clr = 8'h00;
		fsr_set = 8'h00;
		fsr_clr = 8'h00;
		sr_set[SR_WIP] = start_prog;
		sr_clr[SR_WIP] = end_op;
		sr_set[SR_WEL] = wren_cmd_in && state_q == ST_IDLE;
		sr_clr[SR_WEL] = end_op;
		fsr_set[FSR_PROT] = prot_hit;
		fsr_set[FSR_PROG] = prot_hit || timeout;
		fsr_clr[FSR_PROT] = clr_req;
		fsr_clr[FSR_PROG] = clr_req;
		fsr_clr[FSR_ERASE] = clr_req;
		// a new event wins over a clear in the same cycle
		sr_d = (sr_q & ~sr_clr) | sr_set;
		fsr_d = (fsr_q & ~fsr_clr) | fsr_set;
		fsr_d[FSR_SUSP] = (state_q == ST_SUSP);
		fsr_d[FSR_READY] = !sr_d[SR_WIP];
	end

	// both registers update every cycle, busy or not
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			sr_q <= SR_RESET;
			fsr_q <= FSR_RESET;
		end else begin
			sr_q <= sr_d;
			fsr_q <= fsr_d;
		end
	end

	// outputs come straight from flops and stay live while busy
	assign status_out = sr_q;
	assign flag_status_out = fsr_q;
	assign arr_req_out = arr_q;

endmodule

`default_nettype wire

/* hw/sfp_page_buf.sv */
// Purpose: page staging buffer, written from the link clock, read by mclk
// Assumes: reads happen only while the link clock stands still
// Notes: a valid bit per byte keeps unsent bytes of the page untouched
`default_nettype none

module sfp_page_buf #(
	parameter int PAGE_BYTES = sfp_pkg::PAGE_BYTES_DEF,
	localparam int OFF_W = $clog2(PAGE_BYTES)
) (
	// link side write port
	input wire logic wclk_in,
	input wire logic reset_in,
	input wire logic clr_in,
	input wire logic wr_en_in,
	input wire logic [OFF_W-1:0] wr_off_in,
	input wire logic [7:0] wr_data_in,
	// sequencer side read port
	input wire logic [OFF_W-1:0] rd_off_in,
	output logic [7:0] rd_data_out,
	output logic rd_valid_out
);
	import sfp_pkg::*;

	logic [7:0] mem_q [PAGE_BYTES]; // page data, no reset needed
	logic [PAGE_BYTES-1:0] vld_q; // byte holds fresh data

	// later bytes simply overwrite earlier ones at the same offset
	always_ff @(posedge wclk_in) begin
		if (wr_en_in) begin
			mem_q[wr_off_in] <= wr_data_in;
		end
	end

	// valid map: cleared at the start of a frame that begins while not busy, set per written byte
	always_ff @(posedge wclk_in or posedge reset_in) begin
		if (reset_in) begin
			vld_q <= '0;
		end else if (clr_in) begin
			vld_q <= '0;
		end else if (wr_en_in) begin
			vld_q[wr_off_in] <= 1'b1;
		end
	end

	// quasi-static read, the writer is frozen while it is used
	assign rd_data_out = mem_q[rd_off_in];
	assign rd_valid_out = vld_q[rd_off_in];

endmodule

`default_nettype wire

/* hw/sfp_pkg.sv */
// Purpose: shared constants, types and helpers of the flash program sequencer
// Assumes: 24-bit addressing, byte-wide array port, 20 MHz system clock
// Notes: opcode values and status bit positions live here only
`default_nettype none

package sfp_pkg;

	// address geometry
	localparam int ADDR_W = 24;
	localparam int ADDR_BYTES = 3;
	localparam int PAGE_BYTES_DEF = 256;
	localparam int SECT_LSB = 16;
	localparam int NUM_SECT = 1 << (ADDR_W - SECT_LSB);

	// bits moved per link clock edge
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] W_SINGLE = 4'h1;
	localparam logic [3:0] W_DUAL = 4'h2;
	localparam logic [3:0] W_QUAD = 4'h4;
	localparam logic [15:0] DCNT_MAX = 16'hFFFF;

	// command codes handled here
	localparam logic [7:0] OP_CLR_FLAG = 8'h50;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_PP_DUAL = 8'hA2;
	localparam logic [7:0] OP_PP_DUAL_EXT = 8'hD2;
	localparam logic [7:0] OP_PP_QUAD = 8'h32;
	localparam logic [7:0] OP_PP_QUAD_EXT = 8'h38;

	// status register bit positions
	localparam int SR_WIP = 0;
	localparam int SR_WEL = 1;
	// flag status register bit positions
	localparam int FSR_PROT = 1;
	localparam int FSR_SUSP = 2;
	localparam int FSR_PROG = 4;
	localparam int FSR_ERASE = 5;
	localparam int FSR_READY = 7;
	localparam logic [7:0] SR_RESET = 8'h00;
	localparam logic [7:0] FSR_RESET = 8'h80;

	// timing base
	localparam int MCLK_MHZ = 20;
	localparam int NS_PER_US = 1000;
	localparam int TPP_MAX_NS_DEF = 1000000;

	// protocol selected by configuration
	typedef enum logic [1:0] {
		MODE_EXT = 2'h0,
		MODE_DUAL = 2'h1,
		MODE_QUAD = 2'h2
	} sfp_mode_e;

	// position within a link frame
	typedef enum logic [3:0] {
		PH_CMD = 4'b0001,
		PH_ADDR = 4'b0010,
		PH_DATA = 4'b0100,
		PH_OTHER = 4'b1000
	} sfp_phase_e;

	// program sequencer states
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_SCAN = 6'b000010,
		ST_RMW = 6'b000100,
		ST_WACK = 6'b001000,
		ST_SUSP = 6'b010000,
		ST_FINISH = 6'b100000
	} sfp_state_e;

	// what the link side saw in the last frame
	typedef struct packed {
		logic [7:0] opcode;
		sfp_phase_e phase;
		logic [3:0] bits;
		logic [ADDR_W-1:0] addr;
		logic [15:0] dcnt;
		logic blocked;
	} sfp_frame_s;

	// one write request to the storage array
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic we;
	} sfp_arr_req_s;

	// true for every page-program style opcode
	function automatic logic sfp_is_prog(input logic [7:0] op);
		return (op == OP_PP) || (op == OP_PP_DUAL) ||
			(op == OP_PP_DUAL_EXT) || (op == OP_PP_QUAD) ||
			(op == OP_PP_QUAD_EXT);
	endfunction

endpackage

`default_nettype wire

/* sim/sfp_flash_seq_tb.sv */
// Purpose: self-checking bench of the program and flag-clear sequencer
// Assumes: array model answers one cycle after each write request
// Notes: only the low 64KB is modelled; other sectors never get written
`default_nettype none

module sfp_flash_seq_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import sfp_pkg::*;

	localparam int TPP_NS = 150000; // 3000 mclk cycles, fits a full page
	logic mclk_in = 1'b0;
	logic reset_in = 1'b1;
	logic sclk, sel_n;
	logic [3:0] lanes;
	sfp_mode_e mode = MODE_EXT;
	logic wren = 1'b0, susp = 1'b0, resume = 1'b0;
	logic [NUM_SECT-1:0] prot = '0;
	logic [7:0] rdata, status, flags;
	logic ack = 1'b0, ack_en = 1'b1;
	sfp_arr_req_s req;
	logic [7:0] mem [0:65535]; // array contents
	logic [7:0] exp_mem [0:65535]; // what the array should hold
	int mismatches = 0, checks_done = 0;

	always #25 mclk_in = ~mclk_in;

	sfp_flash_seq #(.PAGE_BYTES(256), .TPP_MAX_NS(TPP_NS)) i_dut (
		.mclk_in(mclk_in), .reset_in(reset_in), .sclk_in(sclk),
		.sel_n_in(sel_n), .io_lane_in(lanes), .lane_mode_in(mode),
		.wren_cmd_in(wren), .suspend_req_in(susp),
		.resume_req_in(resume), .sect_prot_in(prot),
		.arr_rdata_in(rdata), .arr_ack_in(ack), .arr_req_out(req),
		.status_out(status), .flag_status_out(flags));
	sfp_host_model i_host (.mode_in(mode), .sclk_out(sclk),
		.sel_n_out(sel_n), .lanes_out(lanes));

	// array model: ack can be withheld to force a timeout
	assign rdata = mem[req.addr[15:0]];
	always @(posedge mclk_in) begin
		ack <= req.we && !ack && ack_en;
		if (req.we && ack) mem[req.addr[15:0]] <= req.wdata;
	end

	task automatic check_eq(input logic [7:0] seen, input logic [7:0] want);
		checks_done++;
		if (seen !== want) begin
			mismatches++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// page offset of the k-th data byte
	function automatic logic [7:0] page_off(input logic [7:0] a, input int k);
		return 8'(a + k);
	endfunction

	// bounded wait on one status (fl=0) or flag (fl=1) bit
	task automatic wait_bit(input logic fl, input int idx, input logic lvl,
		input int lim);
		int n;
		n = 0;
		while ((fl ? flags[idx] : status[idx]) !== lvl && n < lim) begin
			@(posedge mclk_in);
			#1;
			n++;
		end
		check_eq({7'h00, fl ? flags[idx] : status[idx]}, {7'h00, lvl});
	endtask

	task automatic check_page(input logic [15:0] a);
		for (int i = 0; i < 256; i++)
			check_eq(mem[{a[15:8], 8'(i)}], exp_mem[{a[15:8], 8'(i)}]);
	endtask

	task automatic pulse(input int which);
		@(posedge mclk_in);
		if (which == 0) wren <= 1'b1;
		if (which == 1) susp <= 1'b1;
		if (which == 2) resume <= 1'b1;
		@(posedge mclk_in);
		wren <= 1'b0;
		susp <= 1'b0;
		resume <= 1'b0;
	endtask

	// random data frame; expectation built only when it should land
	task automatic start_prog(input logic [7:0] op, input logic [23:0] a,
		input int n, input int extra, input logic upd, input logic en);
		logic [7:0] d[$];
		logic [7:0] st [0:255];
		logic [255:0] hit;
		hit = '0;
		for (int k = 0; k < n; k++) begin
			d.push_back(8'($urandom));
			st[page_off(a[7:0], k)] = d[k];
			hit[page_off(a[7:0], k)] = 1'b1;
		end
		for (int i = 0; i < 256; i++)
			if (upd && hit[i]) exp_mem[{a[15:8], 8'(i)}] &= st[i];
		if (en) pulse(0);
		repeat (2) @(posedge mclk_in);
		i_host.frame(op, a, d, extra);
		repeat (5) @(posedge mclk_in);
		#1;
	endtask

	initial begin
		#(50 * 90000);
		mismatches++;
		give_verdict();
	end

	initial begin
		logic [7:0] ops [0:6];
		sfp_mode_e modes [0:6];
		logic [7:0] none_q[$];
		logic [23:0] a;
		ops = '{OP_PP, OP_PP_DUAL, OP_PP_DUAL_EXT, OP_PP_QUAD, OP_PP_QUAD_EXT,
			OP_PP_DUAL, OP_PP_QUAD_EXT};
		modes = '{MODE_EXT, MODE_EXT, MODE_EXT, MODE_EXT, MODE_EXT,
			MODE_DUAL, MODE_QUAD};
		void'($urandom(32'h0000_B0A8));
		for (int i = 2; i < NUM_SECT; i++) prot[i] = 1'($urandom);
		prot[1] = 1'b1;
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'($urandom);
			exp_mem[i] = mem[i];
		end
		repeat (10) @(posedge mclk_in);
		reset_in <= 1'b0;
		repeat (5) @(posedge mclk_in);
		#1;
		check_eq(status, SR_RESET);
		check_eq(flags, FSR_RESET);
		start_prog(OP_PP, 24'h00_0010, 4, 0, 1'b0, 1'b0);
		check_eq(status, 8'h00);
		check_page(16'h0000);
		$display("reset and refusal test done");
		for (int t = 0; t < 7; t++) begin
			a = {8'h00, 8'($urandom), t == 0 ? 8'hFC : 8'($urandom)};
			mode <= modes[t];
			// a throwaway frame lets a new mode pass the link synchroniser
			i_host.frame(8'h00, 24'h00_0000, none_q, 0);
			start_prog(ops[t], a, t == 0 ? 9 : 1 + $urandom_range(11), 0, 1, 1);
			check_eq(status, 8'h03);
			check_eq(flags, 8'h00);
			wait_bit(1'b0, SR_WIP, 1'b0, 1800);
			check_eq(status, 8'h00);
			check_page(a[15:0]);
		end
		mode <= MODE_EXT;
		i_host.frame(8'h00, 24'h00_0000, none_q, 0);
		a = {8'h00, 8'($urandom), 8'($urandom)};
		start_prog(OP_PP_QUAD_EXT, a, 260, 0, 1, 1);
		wait_bit(1'b0, SR_WIP, 1'b0, 2400);
		check_page(a[15:0]);
		$display("opcode and page tests done");
		start_prog(OP_PP, 24'h01_0040, 2, 0, 0, 1);
		check_eq(status, 8'h02);
		check_eq(flags, 8'h92);
		i_host.frame(OP_CLR_FLAG, 24'h00_0000, none_q, $urandom_range(1, 7));
		repeat (5) @(posedge mclk_in);
		#1;
		check_eq(flags, 8'h80);
		start_prog(OP_PP, a, 3, 3, 0, 0);
		check_eq(status, 8'h02);
		check_eq(flags, 8'h80);
		check_page(a[15:0]);
		$display("protection, clear and boundary tests done");
		start_prog(OP_PP_DUAL, a, 6, 0, 1, 1);
		pulse(1);
		wait_bit(1'b1, FSR_SUSP, 1'b1, 400);
		repeat (20) @(posedge mclk_in);
		#1;
		check_eq(flags, 8'h04);
		check_eq(status, 8'h03);
		pulse(2);
		wait_bit(1'b0, SR_WIP, 1'b0, 1800);
		check_eq(status, 8'h00);
		check_page(a[15:0]);
		$display("suspend test done");
		ack_en <= 1'b0;
		start_prog(OP_PP, a, 2, 0, 0, 1);
		wait_bit(1'b0, SR_WIP, 1'b0, 3200);
		check_eq(status, 8'h00);
		check_eq(flags, 8'h90);
		ack_en <= 1'b1;
		i_host.frame(OP_CLR_FLAG, 24'h00_0000, none_q, 0);
		repeat (5) @(posedge mclk_in);
		#1;
		check_eq(flags, 8'h80);
		$display("timeout test done");
		give_verdict();
	end
endmodule

`default_nettype wire

/* sim/sfp_host_model.sv */
// Purpose: host controller that sends frames over the serial link
// Assumes: frames are started only by the bench
// Notes: sclk stands still between frames; idle lanes keep toggling
`default_nettype none

module sfp_host_model (
	// lane setting shared with the device
	input wire sfp_pkg::sfp_mode_e mode_in,
	// serial link
	output logic sclk_out,
	output logic sel_n_out,
	output logic [3:0] lanes_out
);
	timeunit 1ns;
	timeprecision 100ps;
	import sfp_pkg::*;

	initial begin
		sclk_out = 1'b0;
		sel_n_out = 1'b1;
		lanes_out = 4'h5;
	end

	// released lanes never keep a stale value
	always #48 if (sel_n_out) lanes_out = ~lanes_out;

	// lanes per edge for address (data=0) or data phase
	function automatic int lane_w(input logic [7:0] op, input logic data);
		if (mode_in == MODE_QUAD) return 4;
		if (mode_in == MODE_DUAL) return 2;
		case (op)
			OP_PP_DUAL: return data ? 2 : 1;
			OP_PP_DUAL_EXT: return 2;
			OP_PP_QUAD: return data ? 4 : 1;
			OP_PP_QUAD_EXT: return 4;
			default: return 1;
		endcase
	endfunction

	// one byte, most significant first, w lanes per rising edge
	task automatic send_byte(input logic [7:0] b, input int w);
		for (int i = 8 / w - 1; i >= 0; i--) begin
			lanes_out = ~lanes_out;
			for (int j = 0; j < w; j++) lanes_out[j] = b[i * w + j];
			#24 sclk_out = 1'b1;
			#24 sclk_out = 1'b0;
		end
	endtask

	// whole frame; extra stray clocks leave it off a byte boundary
	task automatic frame(input logic [7:0] op, input logic [23:0] a,
		input logic [7:0] d[$], input int extra);
		#13 sel_n_out = 1'b0;
		send_byte(op, lane_w(8'h00, 1'b0));
		if (op != OP_CLR_FLAG) begin
			for (int k = 2; k >= 0; k--) send_byte(a[k*8 +: 8], lane_w(op, 1'b0));
			foreach (d[k]) send_byte(d[k], lane_w(op, 1'b1));
		end
		repeat (extra) begin
			lanes_out = ~lanes_out;
			#24 sclk_out = 1'b1;
			#24 sclk_out = 1'b0;
		end
		#10 sel_n_out = 1'b1;
	endtask
endmodule

`default_nettype wire

/* sim/sfp_seq_monitor.sv */
// Purpose: port-level checks of the program and flag-clear sequencer
// Assumes: all watched signals except select live in the mclk domain
// Notes: select is asynchronous, so only its settled history is used
`default_nettype none

module sfp_seq_monitor (
	// clock and reset
	input wire logic mclk_in,
	input wire logic reset_in,
	// link and array
	input wire logic sel_n_in,
	input wire logic [7:0] arr_rdata_in,
	input wire sfp_pkg::sfp_arr_req_s arr_req_out,
	// status registers
	input wire logic [7:0] status_out,
	input wire logic [7:0] flag_status_out
);
	timeunit 1ns;
	timeprecision 100ps;
	import sfp_pkg::*;

	// one domain, so one clock and one disable for all
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (reset_in);

	AST_READY_INV: assert property (
		flag_status_out[FSR_READY] == !status_out[SR_WIP])
		else $error("ready flag does not mirror busy bit");
	AST_WE_BUSY: assert property (
		arr_req_out.we |-> status_out[SR_WIP])
		else $error("array write while not busy");
	AST_ONES_ZERO: assert property (
		arr_req_out.we |-> ((arr_req_out.wdata & ~arr_rdata_in) == 8'h00))
		else $error("array write would raise a zero bit");
	// a frame is only judged once select has risen and settled
	AST_WIP_AFTER_SEL: assert property (
		$rose(status_out[SR_WIP]) |-> $past(sel_n_in) && $past(sel_n_in, 2))
		else $error("busy rose while select was low");
	AST_END_WEL: assert property (
		$fell(status_out[SR_WIP]) |-> !status_out[SR_WEL])
		else $error("latch still set after program end");
	AST_TIMEOUT: assert property (
		$rose(flag_status_out[FSR_PROG]) && $past(status_out[SR_WIP])
		|-> status_out == 8'h00)
		else $error("program failure without busy and latch clear");
	AST_PROT_PAIR: assert property (
		$rose(flag_status_out[FSR_PROT])
		|-> flag_status_out[FSR_PROG] && status_out[SR_WEL])
		else $error("protection flag without fail flag and latch");
	AST_CLEAR_ALL: assert property (
		$fell(flag_status_out[FSR_PROT])
		|-> !flag_status_out[FSR_PROG] && !flag_status_out[FSR_ERASE])
		else $error("error flags not cleared together");
	AST_SUSP_IDLE: assert property (
		flag_status_out[FSR_SUSP] |-> status_out[SR_WIP] && !arr_req_out.we)
		else $error("array active while suspended");
endmodule

bind sfp_flash_seq sfp_seq_monitor i_mon (
	.mclk_in(mclk_in),
	.reset_in(reset_in),
	.sel_n_in(sel_n_in),
	.arr_rdata_in(arr_rdata_in),
	.arr_req_out(arr_req_out),
	.status_out(status_out),
	.flag_status_out(flag_status_out)
);

`default_nettype wire
